// ---- pkg/standby_pkg.sv ----
// shared constants and types of the standby controller
package standby_pkg;

    // stabilisation select register
    localparam logic [7:0] STAB_SEL_RESET  = 8'h04;
    localparam int unsigned STAB_SEL_LSB   = 0;
    localparam int unsigned STAB_SEL_MSB   = 2;

    // stabilisation wait exponents, wait = 2**exp main oscillator cycles
    localparam logic [4:0] STAB_EXP_SEL0   = 5'h0d;
    localparam logic [4:0] STAB_EXP_SEL1   = 5'h0f;
    localparam logic [4:0] STAB_EXP_SEL2   = 5'h10;
    localparam logic [4:0] STAB_EXP_SEL3   = 5'h11;
    localparam logic [4:0] STAB_EXP_SEL4   = 5'h12;
    localparam logic [4:0] STAB_EXP_RESET  = 5'h11;

    // position of the halving bit in the oscillation mode select register
    localparam int unsigned HALVING_BIT_POS = 0;

    // clocks from halt release to processor restart
    localparam logic [3:0] RESUME_VEC_CYC  = 4'h8;
    localparam logic [3:0] RESUME_NEXT_CYC = 4'h2;

    typedef enum logic [2:0] {SRC_NONE, SRC_RESET, SRC_NMI, SRC_IRQ, SRC_TEST} src_t;

    typedef enum logic [2:0] {ST_RUN, ST_HALT, ST_STOP, ST_STAB, ST_RESUME, ST_RESET} mode_t;

endpackage

// ---- pkg/standby_if.sv ----
// release arbitration and stabilisation counter links
`timescale 1ns/1ps
interface standby_if;
    logic                 rst;
    logic                 nmi;
    logic                 irq;
    logic                 test;
    standby_pkg::src_t    winner;
    logic                 any;
    logic                 start;
    logic [7:0]           sel;
    logic                 use_reset_exp;
    logic                 osc_run;
    logic                 done;

    modport arb  (input rst, nmi, irq, test, output winner, any);
    modport stab (input start, sel, use_reset_exp, osc_run, output done);
    modport ctl  (output rst, nmi, irq, test, start, sel, use_reset_exp, osc_run,
                  input winner, any, done);
endinterface

// ---- core/release_arbiter.sv ----
// fixed-priority choice among standby release sources
`timescale 1ns/1ps
module release_arbiter
(
    standby_if.arb sb
);
    always_comb
    begin
        sb.any    = 1'b1;
        if (sb.rst)
            sb.winner = standby_pkg::SRC_RESET;
        else if (sb.nmi)
            sb.winner = standby_pkg::SRC_NMI;
        else if (sb.irq)
            sb.winner = standby_pkg::SRC_IRQ;
        else if (sb.test)
            sb.winner = standby_pkg::SRC_TEST;
        else
        begin
            sb.winner = standby_pkg::SRC_NONE;
            sb.any    = 1'b0;
        end
    end
endmodule

// ---- core/stab_counter.sv ----
// oscillation stabilisation wait counter
`timescale 1ns/1ps
module stab_counter #(
    parameter int unsigned CNT_W    = 18,
    parameter int unsigned EXP_TRIM = 0
)
(
    input  wire logic      clk,
    input  wire logic      rst_n,
    standby_if.stab        sb
);
    typedef struct packed {
        logic             busy;
        logic             done;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] last;
    } stab_state_t;

    stab_state_t s_r;
    stab_state_t s_nxt;
    logic [4:0]  exp_sel;
    logic [4:0]  exp_raw;
    logic [4:0]  exp_eff;

    always_comb
    begin
        unique case (sb.sel[standby_pkg::STAB_SEL_MSB:standby_pkg::STAB_SEL_LSB])
            3'h0:    exp_sel = standby_pkg::STAB_EXP_SEL0;
            3'h1:    exp_sel = standby_pkg::STAB_EXP_SEL1;
            3'h2:    exp_sel = standby_pkg::STAB_EXP_SEL2;
            3'h3:    exp_sel = standby_pkg::STAB_EXP_SEL3;
            // prohibited codes fall back to the longest wait
            default: exp_sel = standby_pkg::STAB_EXP_SEL4;
        endcase
        exp_raw = sb.use_reset_exp ? standby_pkg::STAB_EXP_RESET : exp_sel;
        exp_eff = (32'(exp_raw) > EXP_TRIM + 1) ? 5'(32'(exp_raw) - EXP_TRIM) : 5'h1;
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        if (sb.start)
        begin
            s_nxt.busy = 1'b1;
            s_nxt.cnt  = '0;
            s_nxt.last = CNT_W'((32'h1 << exp_eff) - 32'h1);
        end
        else if (s_r.busy && sb.osc_run)
        begin
            if (s_r.cnt == s_r.last)
            begin
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
            end
            else
                s_nxt.cnt = s_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign sb.done = s_r.done;

    property p_count_frozen;
        @(posedge clk) disable iff (!rst_n)
        s_r.busy && !sb.osc_run && !sb.start |=> $stable(s_r.cnt) && !s_r.done;
    endproperty
    a_count_frozen: assert property (p_count_frozen) else $error("wait counted without oscillation");

    property p_reset_len;
        @(posedge clk) disable iff (!rst_n)
        sb.start && sb.use_reset_exp |=> s_r.last == CNT_W'((32'h1 << (17 - EXP_TRIM)) - 32'h1);
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("reset wait is not 2**17");
endmodule

// ---- core/standby_halt_stop_control.sv ----
// halt/stop standby controller with stabilisation wait and bus parking
// How it works
// - halt instruction gates processor clock, oscillator keeps running.
// - stop instruction turns the main oscillator off, except on subclock, where it is ignored.
// - during standby, processor state and port latches are frozen; bus data lines float and strobes park.
// - an interrupt request releases stop mode.
// - after stop release a stabilisation wait from the select register runs.
// - reset loads select register with 04h; software writes it whole.
// - stop released by reset waits 2**17 oscillator cycles.
// - wait counts only once the oscillator runs again.
// - peripheral clock is oscillator rate or half, by mode bit 0.
// - halt cuts processor clock; both oscillators stay enabled.
// - subclock halt with main stopped: 16-bit timer runs only from watch timer.
// - same case: 8-bit timers run only from external pin clock.
// - same case: watch timer runs only from subsystem clock.
// - halt: serial runs, or external clock only; auto transfer stops.
// - external irq zero in halt needs main clock and peripheral sampling.
// - standby floats data lines and wait, holds address, parks strobes.
// - halt released by interrupt, non-maskable, test input or reset.
// - halt release restarts after 8 clocks vectored, 2 clocks otherwise.
// - stop with pending unmasked interrupt falls back to a stabilisation wait.
// - non-maskable interrupt releases halt into vectored service always.
`timescale 1ns/1ps
module standby_halt_stop_control #(
    parameter int unsigned EXP_TRIM = 0,
    parameter int unsigned CNT_W    = 18
)
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        halt_exec,
    input  wire logic        stop_exec,
    input  wire logic        reset_in,
    input  wire logic        irq_pending,
    input  wire logic        irq_ack_en,
    input  wire logic        nmi_req,
    input  wire logic        test_req,
    input  wire logic        on_subclock,
    input  wire logic        main_osc_off,
    input  wire logic        osc_running,
    input  wire logic        sel_wr,
    input  wire logic [7:0]  sel_wdata,
    input  wire logic [7:0]  osc_mode_select_reg,
    input  wire logic        tm16_src_watch,
    input  wire logic        tm8_src_ext,
    input  wire logic        wt_src_sub,
    input  wire logic        sio_ext_clk,
    input  wire logic        irq_zero_periph_clk,
    input  wire logic [7:0]  core_ad_o,
    input  wire logic        core_ad_oe,
    input  wire logic [15:0] core_addr,
    input  wire logic        core_latch_stb,
    input  wire logic        core_rd_n,
    input  wire logic        core_wr_n,
    input  wire logic        core_wait_en,
    output logic             cpu_clk_en,
    output logic             osc_enable,
    output logic             cpu_reset,
    output logic             resume_vectored,
    output logic             resume_next,
    output logic             periph_clk_en,
    output logic [7:0]       stab_wait_select_reg,
    output logic             tm16_run,
    output logic             tm8_run,
    output logic             wt_run,
    output logic             sio_run,
    output logic             sio_auto_run,
    output logic             ext_irq_zero_run,
    output logic [7:0]       muxed_addr_data_lines_o,
    output logic             muxed_addr_data_lines_oe,
    output logic [15:0]      upper_address_lines,
    output logic             address_latch_strobe,
    output logic             rd_n,
    output logic             wr_n,
    output logic             wait_in_en
);
    typedef struct packed {
        standby_pkg::mode_t st;
        logic               vec;
        logic               from_stop;
        logic               rst_wait;
        logic               start;
        logic [3:0]         rcnt;
        logic [7:0]         sel;
        logic               div;
        logic               pclk;
        logic               cpu_en;
        logic               osc_en;
        logic               cpu_rst;
        logic               res_vec;
        logic               res_next;
        logic [5:0]         prun;
        logic [7:0]         ad_o;
        logic               ad_oe;
        logic [15:0]        addr;
        logic               ale;
        logic               rd_n;
        logic               wr_n;
        logic               wait_en;
    } ctl_state_t;

    ctl_state_t s_r;
    ctl_state_t s_nxt;
    standby_if  sb();

    release_arbiter u_arb
    (
        .sb (sb.arb)
    );

    stab_counter #(
        .CNT_W    (CNT_W),
        .EXP_TRIM (EXP_TRIM)
    ) u_stab
    (
        .clk   (clk),
        .rst_n (rst_n),
        .sb    (sb.stab)
    );

    assign sb.rst           = reset_in;
    assign sb.nmi           = nmi_req;
    assign sb.irq           = irq_pending;
    assign sb.test          = test_req;
    assign sb.start         = s_r.start;
    assign sb.sel           = s_r.sel;
    assign sb.use_reset_exp = s_r.rst_wait;
    assign sb.osc_run       = osc_running;

    logic quiet;
    logic halted;
    logic stopped;
    logic low_clk;
    logic vec_pick;
    logic halving;

    always_comb
    begin
        s_nxt          = s_r;
        s_nxt.start    = 1'b0;
        s_nxt.res_vec  = 1'b0;
        s_nxt.res_next = 1'b0;
        // nmi always vectors, maskable only when acknowledge is enabled
        vec_pick = (sb.winner == standby_pkg::SRC_NMI)
                   || (sb.winner == standby_pkg::SRC_IRQ && irq_ack_en);
        if (sel_wr)
            s_nxt.sel = sel_wdata;
        unique case (s_r.st)
            standby_pkg::ST_RUN:
            begin
                if (halt_exec)
                    s_nxt.st = standby_pkg::ST_HALT;
                else if (stop_exec && !on_subclock)
                begin
                    if (irq_pending)
                    begin
                        // pending request: oscillator never stops
                        s_nxt.st       = standby_pkg::ST_STAB;
                        s_nxt.start    = 1'b1;
                        s_nxt.rst_wait = 1'b0;
                        s_nxt.vec      = irq_ack_en;
                    end
                    else
                        s_nxt.st = standby_pkg::ST_STOP;
                end
            end
            standby_pkg::ST_HALT:
            begin
                if (sb.any)
                begin
                    s_nxt.st   = standby_pkg::ST_RESUME;
                    s_nxt.vec  = vec_pick;
                    s_nxt.rcnt = vec_pick ? 4'(standby_pkg::RESUME_VEC_CYC - 4'h1)
                                          : 4'(standby_pkg::RESUME_NEXT_CYC - 4'h1);
                end
            end
            standby_pkg::ST_STOP:
            begin
                if (sb.any)
                begin
                    s_nxt.st       = standby_pkg::ST_STAB;
                    s_nxt.start    = 1'b1;
                    s_nxt.rst_wait = 1'b0;
                    s_nxt.vec      = vec_pick;
                end
            end
            standby_pkg::ST_STAB:
            begin
                if (sb.done)
                begin
                    if (s_r.rst_wait)
                        s_nxt.st = standby_pkg::ST_RUN;
                    else
                    begin
                        s_nxt.st   = standby_pkg::ST_RESUME;
                        s_nxt.rcnt = s_r.vec ? 4'(standby_pkg::RESUME_VEC_CYC - 4'h1)
                                             : 4'(standby_pkg::RESUME_NEXT_CYC - 4'h1);
                    end
                end
            end
            standby_pkg::ST_RESUME:
            begin
                if (s_r.rcnt == 4'h0)
                begin
                    s_nxt.st       = standby_pkg::ST_RUN;
                    s_nxt.res_vec  = s_r.vec;
                    s_nxt.res_next = !s_r.vec;
                end
                else
                    s_nxt.rcnt = s_r.rcnt - 4'h1;
            end
            standby_pkg::ST_RESET:
            begin
                if (s_r.from_stop)
                begin
                    // clock was off: take the fixed reset wait
                    s_nxt.st       = standby_pkg::ST_STAB;
                    s_nxt.start    = 1'b1;
                    s_nxt.rst_wait = 1'b1;
                end
                else
                    s_nxt.st = standby_pkg::ST_RUN;
                s_nxt.from_stop = 1'b0;
            end
            default:
                s_nxt.st = standby_pkg::ST_RESET;
        endcase
        if (reset_in)
        begin
            s_nxt.from_stop = (s_r.st == standby_pkg::ST_STOP)
                              || (s_r.st == standby_pkg::ST_RESET && s_r.from_stop)
                              || (s_r.st == standby_pkg::ST_STAB && s_r.rst_wait);
            s_nxt.st       = standby_pkg::ST_RESET;
            s_nxt.start    = 1'b0;
            s_nxt.sel      = standby_pkg::STAB_SEL_RESET;
            s_nxt.res_vec  = 1'b0;
            s_nxt.res_next = 1'b0;
        end

        // outputs follow the next mode so they line up with s_r.st
        quiet   = s_nxt.st != standby_pkg::ST_RUN;
        halted  = s_nxt.st == standby_pkg::ST_HALT;
        stopped = s_nxt.st == standby_pkg::ST_STOP;
        low_clk = stopped || (halted && on_subclock && main_osc_off);
        halving = osc_mode_select_reg[standby_pkg::HALVING_BIT_POS];
        s_nxt.cpu_en  = !quiet;
        s_nxt.osc_en  = !stopped;
        s_nxt.cpu_rst = s_nxt.st == standby_pkg::ST_RESET
                        || (s_nxt.st == standby_pkg::ST_STAB && s_nxt.rst_wait);
        s_nxt.div  = !s_r.div;
        s_nxt.pclk = !stopped && (!halving || s_r.div);
        s_nxt.prun[0] = !low_clk || tm16_src_watch;
        s_nxt.prun[1] = !low_clk || tm8_src_ext;
        s_nxt.prun[2] = !low_clk || wt_src_sub;
        s_nxt.prun[3] = !low_clk || sio_ext_clk;
        s_nxt.prun[4] = !(halted || stopped);
        s_nxt.prun[5] = !(halted || stopped)
                        || (halted && !low_clk && irq_zero_periph_clk);
        if (quiet)
        begin
            s_nxt.ad_oe   = 1'b0;
            s_nxt.ale     = 1'b0;
            s_nxt.rd_n    = 1'b1;
            s_nxt.wr_n    = 1'b1;
            s_nxt.wait_en = 1'b0;
        end
        else
        begin
            s_nxt.ad_o    = core_ad_o;
            s_nxt.ad_oe   = core_ad_oe;
            s_nxt.addr    = core_addr;
            s_nxt.ale     = core_latch_stb;
            s_nxt.rd_n    = core_rd_n;
            s_nxt.wr_n    = core_wr_n;
            s_nxt.wait_en = core_wait_en;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r         <= '0;
            s_r.st      <= standby_pkg::ST_RESET;
            s_r.sel     <= standby_pkg::STAB_SEL_RESET;
            s_r.cpu_rst <= 1'b1;
            s_r.osc_en  <= 1'b1;
            s_r.rd_n    <= 1'b1;
            s_r.wr_n    <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    assign cpu_clk_en               = s_r.cpu_en;
    assign osc_enable               = s_r.osc_en;
    assign cpu_reset                = s_r.cpu_rst;
    assign resume_vectored          = s_r.res_vec;
    assign resume_next              = s_r.res_next;
    assign periph_clk_en            = s_r.pclk;
    assign stab_wait_select_reg     = s_r.sel;
    assign tm16_run                 = s_r.prun[0];
    assign tm8_run                  = s_r.prun[1];
    assign wt_run                   = s_r.prun[2];
    assign sio_run                  = s_r.prun[3];
    assign sio_auto_run             = s_r.prun[4];
    assign ext_irq_zero_run         = s_r.prun[5];
    assign muxed_addr_data_lines_o  = s_r.ad_o;
    assign muxed_addr_data_lines_oe = s_r.ad_oe;
    assign upper_address_lines      = s_r.addr;
    assign address_latch_strobe     = s_r.ale;
    assign rd_n                     = s_r.rd_n;
    assign wr_n                     = s_r.wr_n;
    assign wait_in_en               = s_r.wait_en;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_halt_entry;
        s_r.st == standby_pkg::ST_RUN && halt_exec && !reset_in
        |=> !cpu_clk_en && osc_enable && s_r.st == standby_pkg::ST_HALT;
    endproperty
    a_halt_entry: assert property (p_halt_entry) else $error("halt entry wrong");

    property p_stop_entry;
        s_r.st == standby_pkg::ST_RUN && stop_exec && !halt_exec && !on_subclock
        && !irq_pending && !reset_in |=> !osc_enable && !cpu_clk_en;
    endproperty
    a_stop_entry: assert property (p_stop_entry) else $error("stop kept oscillator");

    property p_stop_fallback;
        s_r.st == standby_pkg::ST_RUN && stop_exec && !halt_exec && !on_subclock
        && irq_pending && !reset_in |=> osc_enable && s_r.st == standby_pkg::ST_STAB;
    endproperty
    a_stop_fallback: assert property (p_stop_fallback) else $error("no stop fallback");

    property p_stop_wake;
        s_r.st == standby_pkg::ST_STOP && irq_pending && !reset_in
        |=> osc_enable ##1 sb.start == 1'b0;
    endproperty
    a_stop_wake: assert property (p_stop_wake) else $error("irq did not wake stop");

    property p_bus_park;
        s_r.st == standby_pkg::ST_HALT && $past(s_r.st) == standby_pkg::ST_HALT
        |-> !muxed_addr_data_lines_oe && !address_latch_strobe && rd_n && wr_n
            && !wait_in_en && $stable(upper_address_lines);
    endproperty
    a_bus_park: assert property (p_bus_park) else $error("bus not parked in halt");

    property p_vec_resume;
        ($rose(s_r.st == standby_pkg::ST_RESUME) && s_r.vec && !reset_in)
        ##1 (!reset_in)[*7] |-> !cpu_clk_en ##1 (cpu_clk_en && resume_vectored);
    endproperty
    a_vec_resume: assert property (p_vec_resume) else $error("vectored resume not 8");

    property p_next_resume;
        ($rose(s_r.st == standby_pkg::ST_RESUME) && !s_r.vec && !reset_in)
        ##1 !reset_in |-> !cpu_clk_en ##1 (cpu_clk_en && resume_next);
    endproperty
    a_next_resume: assert property (p_next_resume) else $error("plain resume not 2");

    property p_nmi_wake;
        s_r.st == standby_pkg::ST_HALT && nmi_req && !reset_in
        |=> s_r.st == standby_pkg::ST_RESUME && s_r.vec;
    endproperty
    a_nmi_wake: assert property (p_nmi_wake) else $error("nmi release not vectored");

    property p_reset_first;
        reset_in |=> s_r.st == standby_pkg::ST_RESET && cpu_reset
                     && stab_wait_select_reg == standby_pkg::STAB_SEL_RESET;
    endproperty
    a_reset_first: assert property (p_reset_first) else $error("reset not first");

    property p_stab_gate;
        s_r.st == standby_pkg::ST_STAB |-> !cpu_clk_en && osc_enable;
    endproperty
    a_stab_gate: assert property (p_stab_gate) else $error("cpu clocked during wait");

    property p_halving;
        halving && $past(halving) && periph_clk_en |=> !periph_clk_en;
    endproperty
    a_halving: assert property (p_halving) else $error("peripheral clock not halved");

    c_halt_vec:  cover property (s_r.st == standby_pkg::ST_HALT ##[1:20] resume_vectored);
    c_stop_run:  cover property (s_r.st == standby_pkg::ST_STOP ##[1:1000] sb.done);
    c_rst_stop:  cover property (s_r.st == standby_pkg::ST_STAB && s_r.rst_wait);
    c_fallback:  cover property (s_r.st == standby_pkg::ST_RUN && stop_exec && irq_pending);
endmodule

// ---- sim/osc_model.sv ----
// main oscillator start-up model for the standby bench
`timescale 1ns/1ps
module osc_model #(
    parameter int unsigned DLY = 5
)
(
    input  wire logic clk,
    input  wire logic enable,
    output logic      running
);
    int unsigned cnt;
    // edges come only some cycles after enable, so the wait must not count before
    always_ff @(posedge clk)
    begin
        if (!enable)
        begin
            cnt     <= 0;
            running <= 1'b0;
        end
        else if (cnt < DLY)
            cnt <= cnt + 1;
        else
            running <= 1'b1;
    end
endmodule

// ---- sim/standby_halt_stop_control_test.sv ----
// bench for the standby controller: halt, stop, waits, parking
`timescale 1ns/1ps
module standby_halt_stop_control_test;
    localparam int TRIM = 12;
    localparam logic [7:0] codes [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h07};
    localparam int         ex    [6] = '{13, 15, 16, 17, 18, 18};
    localparam logic [3:0] relz  [5] = '{4'b1100, 4'b1000, 4'b0010, 4'b0001, 4'b0011};
    localparam logic [4:0] vec       = 5'b10101;
    logic clk = 0, rst_n = 0, halt_exec = 0, stop_exec = 0, reset_in = 0, irq_pending = 0;
    logic irq_ack_en = 0, nmi_req = 0, test_req = 0, on_subclock = 0, main_osc_off = 0;
    logic osc_running, sel_wr = 0, tm16_src_watch = 0, tm8_src_ext = 0, wt_src_sub = 0;
    logic sio_ext_clk = 0, irq_zero_periph_clk = 0, core_ad_oe = 1, core_latch_stb = 1;
    logic core_rd_n = 0, core_wr_n = 0, core_wait_en = 1, p;
    logic [7:0]  sel_wdata = 8'h00, osc_mode_select_reg = 8'h00, core_ad_o = 8'h5a;
    logic [15:0] core_addr = 16'h1234, upper_address_lines;
    logic cpu_clk_en, osc_enable, cpu_reset, resume_vectored, resume_next, periph_clk_en;
    logic tm16_run, tm8_run, wt_run, sio_run, sio_auto_run, ext_irq_zero_run;
    logic muxed_addr_data_lines_oe, address_latch_strobe, rd_n, wr_n, wait_in_en;
    logic [7:0]  stab_wait_select_reg, muxed_addr_data_lines_o;
    int errors = 0, n_checks = 0, cnt;

    standby_halt_stop_control #(.EXP_TRIM(TRIM), .CNT_W(18)) dut (
        .clk(clk), .rst_n(rst_n), .halt_exec(halt_exec), .stop_exec(stop_exec),
        .reset_in(reset_in), .irq_pending(irq_pending), .irq_ack_en(irq_ack_en),
        .nmi_req(nmi_req), .test_req(test_req), .on_subclock(on_subclock),
        .main_osc_off(main_osc_off), .osc_running(osc_running), .sel_wr(sel_wr),
        .sel_wdata(sel_wdata), .osc_mode_select_reg(osc_mode_select_reg),
        .tm16_src_watch(tm16_src_watch), .tm8_src_ext(tm8_src_ext), .wt_src_sub(wt_src_sub),
        .sio_ext_clk(sio_ext_clk), .irq_zero_periph_clk(irq_zero_periph_clk),
        .core_ad_o(core_ad_o), .core_ad_oe(core_ad_oe), .core_addr(core_addr),
        .core_latch_stb(core_latch_stb), .core_rd_n(core_rd_n), .core_wr_n(core_wr_n),
        .core_wait_en(core_wait_en), .cpu_clk_en(cpu_clk_en), .osc_enable(osc_enable),
        .cpu_reset(cpu_reset), .resume_vectored(resume_vectored), .resume_next(resume_next),
        .periph_clk_en(periph_clk_en), .stab_wait_select_reg(stab_wait_select_reg),
        .tm16_run(tm16_run), .tm8_run(tm8_run), .wt_run(wt_run), .sio_run(sio_run),
        .sio_auto_run(sio_auto_run), .ext_irq_zero_run(ext_irq_zero_run),
        .muxed_addr_data_lines_o(muxed_addr_data_lines_o),
        .muxed_addr_data_lines_oe(muxed_addr_data_lines_oe),
        .upper_address_lines(upper_address_lines),
        .address_latch_strobe(address_latch_strobe), .rd_n(rd_n), .wr_n(wr_n),
        .wait_in_en(wait_in_en));
    osc_model #(.DLY(5)) osc (.clk(clk), .enable(osc_enable), .running(osc_running));

    always #50 clk = ~clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic enter(input logic stop);
        halt_exec = !stop;
        stop_exec = stop;
        cyc(1);
        halt_exec = 0;
        stop_exec = 0;
    endtask
    // edges from the release until the processor clock runs again, bounded
    task automatic wait_run(output int n);
        n = 0;
        while (cpu_clk_en !== 1'b1 && n < 400)
        begin
            cyc(1);
            n++;
        end
    endtask

    initial
    begin
        cyc(10);
        rst_n = 1;
        cyc(2);
        chk(stab_wait_select_reg, 8'h04);
        for (int i = 0; i < 5; i++)
        begin
            enter(0);
            chk({cpu_clk_en, osc_enable, sio_auto_run, ext_irq_zero_run}, 4'b0100);
            chk({muxed_addr_data_lines_oe, address_latch_strobe, rd_n, wr_n, wait_in_en},
                5'b00110);
            core_addr = 16'hbeef;
            cyc(3);
            chk(upper_address_lines, 16'h1234);
            {irq_pending, irq_ack_en, nmi_req, test_req} = relz[i];
            wait_run(cnt);
            chk(cnt, vec[i] ? 9 : 3);
            chk({resume_vectored, resume_next}, vec[i] ? 2'b10 : 2'b01);
            chk({muxed_addr_data_lines_oe, muxed_addr_data_lines_o, upper_address_lines},
                25'h15abeef);
            {irq_pending, irq_ack_en, nmi_req, test_req} = 4'h0;
            core_addr = 16'h1234;
            cyc(2);
        end
        for (int i = 0; i < 6; i++)
        begin
            sel_wdata = codes[i];
            sel_wr = 1;
            cyc(1);
            sel_wr = 0;
            chk(stab_wait_select_reg, codes[i]);
            enter(1);
            chk(osc_enable, 1'b0);
            cyc(4);
            irq_pending = 1;
            wait_run(cnt);
            irq_pending = 0;
            chk(cnt >= (1 << (ex[i] - TRIM)) + 8 && cnt <= (1 << (ex[i] - TRIM)) + 12, 1);
            cyc(2);
        end
        irq_pending = 1;
        enter(1);
        chk(osc_enable, 1'b1);
        wait_run(cnt);
        irq_pending = 0;
        chk(cnt >= 64 && cnt <= 72, 1);
        sel_wdata = 8'h00;
        sel_wr = 1;
        cyc(1);
        sel_wr = 0;
        enter(1);
        cyc(4);
        reset_in = 1;
        cyc(8);
        chk({cpu_reset, stab_wait_select_reg}, 9'h104);
        reset_in = 0;
        wait_run(cnt);
        chk(cnt >= 32 && cnt <= 38, 1);
        {on_subclock, main_osc_off} = 2'b11;
        enter(1);
        chk({osc_enable, cpu_clk_en}, 2'b11);
        enter(0);
        cyc(2);
        chk({tm16_run, tm8_run, wt_run, ext_irq_zero_run, sio_run}, 5'b00000);
        {tm16_src_watch, tm8_src_ext, wt_src_sub, sio_ext_clk, irq_zero_periph_clk} = 5'h1f;
        cyc(2);
        chk({tm16_run, tm8_run, wt_run, ext_irq_zero_run, sio_run}, 5'b11101);
        test_req = 1;
        wait_run(cnt);
        test_req = 0;
        {on_subclock, main_osc_off} = 2'b00;
        enter(0);
        cyc(2);
        chk({ext_irq_zero_run, sio_run}, 2'b11);
        test_req = 1;
        wait_run(cnt);
        test_req = 0;
        osc_mode_select_reg = 8'h01;
        cyc(2);
        p = periph_clk_en;
        cyc(1);
        chk(periph_clk_en, !p);
        osc_mode_select_reg = 8'h00;
        cyc(2);
        chk(periph_clk_en, 1'b1);
        complete_run();
    end

    initial
    begin
        #(100 * 20000);
        errors++;
        complete_run();
    end
endmodule
